// [eif_asserts.sv]
// checker for the pin interrupt conditioner
`timescale 1ns/1ns
module eif_chk
(
  input wire hclk,
  input wire hresetn,
  input wire hsel,
  input wire [31:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [31:0] hwdata,
  input wire hready,
  input wire [31:0] hrdata,
  input wire hreadyout,
  input wire hresp,
  input wire fixed_irq_pin_a_n,
  input wire fixed_irq_pin_b_n,
  input wire [5:0] irq_req_q
);
  logic rd_q;
  logic wr_q;
  logic gate_q;
  logic [7:0] a_q;
  // the gate bit is rebuilt from bus writes, internals are not visible here
  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      rd_q <= 1'b0;
      wr_q <= 1'b0;
      gate_q <= 1'b0;
      a_q <= 8'h0;
    end
    else
    begin
      rd_q <= hsel & hready & htrans[1] & ~hwrite;
      wr_q <= hsel & hready & htrans[1] & hwrite;
      if (hsel & hready & htrans[1])
        a_q <= haddr[7:0];
      if (wr_q && a_q == 8'h00)
        gate_q <= hwdata[0];
    end
  end
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  ready_a: assert property (hreadyout) else $error("ready low");
  okay_a: assert property (!hresp) else $error("error response");
  gate_off_a: assert property (!gate_q [*3] |-> irq_req_q == 6'h0) else $error("gated req");
  fix_a_a: assert property (irq_req_q[0] |-> !$past(fixed_irq_pin_a_n)) else $error("src0");
  fix_b_a: assert property (irq_req_q[5] |-> !$past(fixed_irq_pin_b_n)) else $error("src5");
  edge_pulse_a: assert property ((irq_req_q & 6'h2f) != 6'h0 |=> (irq_req_q & $past(irq_req_q)
    & 6'h2f) == 6'h0) else $error("long edge req");
  cfg4_zero_a: assert property (rd_q && a_q == 8'h14 |-> hrdata[7:5] == 3'h0) else $error("b75");
  rd_hold_a: assert property ($changed(hrdata) |-> rd_q) else $error("hrdata moved");
  cover property (irq_req_q[0]);
  cover property (irq_req_q[4]);
  cover property (rd_q && a_q == 8'h14);
endmodule // eif_chk
bind eif_top eif_chk eif_chk_i (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
  .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
  .hreadyout(hreadyout), .hresp(hresp), .fixed_irq_pin_a_n(fixed_irq_pin_a_n),
  .fixed_irq_pin_b_n(fixed_irq_pin_b_n), .irq_req_q(irq_req_q));

// [eif_filter.v]
// one pin: sampling noise filter with edge request detection; high-level requests come from eif_top
`timescale 1ns/1ns
`include "eif_map.vh"
module eif_filter
(
  input wire hclk,
  input wire hresetn,
  input wire run,
  input wire pin,
  input wire smp_en,
  input wire [1:0] need,
  input wire [1:0] es,
  input wire fixed,
  output reg filt_q,
  output reg req_q
);
  reg cand_q;
  reg [1:0] cnt_q;
  // widened by one bit so a saturated count cannot wrap below the threshold
  wire [2:0] cnt_next = {1'b0, cnt_q} + 3'h1;
  wire filt_d = (smp_en && pin == cand_q && cnt_next >= {1'b0, need}) ? cand_q : filt_q;
  wire rise = filt_d & ~filt_q;
  wire fall = ~filt_d & filt_q;
  reg hit;
  always @*
  begin
    hit = 1'b0;
    if (fixed)
      hit = fall; // [R2] [R19]
    else
      case (es) // [R5] [R16]
        `EIF_ES_RISE: hit = rise;
        `EIF_ES_FALL: hit = fall;
        `EIF_ES_BOTH: hit = rise | fall;
        default: hit = 1'b0; // [R18]
      endcase
  end
  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      cand_q <= 1'b1;
      cnt_q <= 2'h0;
      filt_q <= 1'b1;
      req_q <= 1'b0;
    end
    else if (!run)
    begin
      // gated or deep mode: frozen, no requests [R9] [R17]
      req_q <= 1'b0;
    end
    else
    begin
      if (smp_en)
      begin
        if (pin != cand_q)
        begin
          cand_q <= pin;
          cnt_q <= 2'h1;
        end
        else if (cnt_q != 2'h3)
          cnt_q <= cnt_q + 2'h1;
      end
      filt_q <= filt_d;
      req_q <= hit;
    end
  end
endmodule // eif_filter

// [eif_map.vh]
// register offsets, field positions, codes and timing constants for the pin interrupt filter
`ifndef EIF_MAP_VH
`define EIF_MAP_VH
// ***************************************************************
// register byte offsets
// ***************************************************************
`define EIF_OFS_GATE 8'h00
`define EIF_OFS_MODE 8'h04
`define EIF_OFS_CFG1 8'h08
`define EIF_OFS_CFG2 8'h0c
`define EIF_OFS_CFG3 8'h10
`define EIF_OFS_CFG4 8'h14
`define EIF_OFS_STAT 8'h18
// ***************************************************************
// config field layout: [1:0] edge, [3:2] interval, [4] monitor
// ***************************************************************
`define EIF_ES_LSB 0
`define EIF_NC_LSB 2
`define EIF_LVL_BIT 4
`define EIF_LVL_SRC 4
`define EIF_ES_RISE 2'h0
`define EIF_ES_FALL 2'h1
`define EIF_ES_BOTH 2'h2
`define EIF_ES_HIGH 2'h3
`define EIF_NC_1 2'h0
`define EIF_NC_4 2'h1
`define EIF_NC_8 2'h2
`define EIF_NC_16 2'h3
// ***************************************************************
// operating modes (mode register bits [1:0])
// ***************************************************************
`define EIF_MODE_FAST 2'h0
`define EIF_MODE_SLOW 2'h1
`define EIF_MODE_DEEP 2'h2
// ***************************************************************
// filter counts
// ***************************************************************
`define EIF_FAST_AGREE 2'h3
`define EIF_SLOW_AGREE 2'h2
`define EIF_FIX_FAST_AGREE 2'h2
`define EIF_SLOW_DIV 2'h3
`endif

// [eif_pins.sv]
// board-side model of the six interrupt pins and the slow clock
`timescale 1ns/1ns
module eif_pins
(
  input wire logic hclk,
  output logic low_freq_clock,
  output logic [5:0] pin_q
);
  logic [1:0] div_q = 2'h0;
  initial low_freq_clock = 1'b0;
  initial pin_q = 6'h3f;
  // slow clock is eight hclk periods, free running as a device clock
  always @(posedge hclk)
  begin
    div_q <= div_q + 2'h1;
    if (div_q == 2'h3)
      low_freq_clock <= ~low_freq_clock;
  end
  task automatic pulse(input logic [5:0] m, input int w);
    @(posedge hclk);
    pin_q <= pin_q ^ m;
    repeat (w) @(posedge hclk);
    pin_q <= pin_q ^ m;
  endtask
endmodule // eif_pins

// [eif_top.v]
// six pin interrupt conditioner with ahb-lite register slave
`timescale 1ns/1ns
`include "eif_map.vh"
// Behaviour
// [R1] sources 1-4 programmable condition and filter; 0 and 5 fixed
// [R2] source 0 requests on filtered falling edge of active-low pin
// [R3] fast modes: fixed filter drops <1 clock, passes >=2 clocks
// [R4] slow modes: all sources drop <4 slow periods, pass >=8
// [R5] sources 1-3 edge code: 00 rise, 01 fall, 10 both, 11 reserved
// [R6] fast modes: programmable filter drops <2 intervals, passes >3+1 clock
// [R7] monitor bit captures filtered level at each request
// [R8] source-4 config bits 7:5 read zero
// [R9] clock gate enable 0 stops logic; 1 runs it
// [R10] clock gate enable resets to 0
// [R11] software sets gate enable before writing config registers
// [R12] software disables interrupt before changing config, gate or mode
// [R13] software waits after mode switch before clearing latch
// [R14] fast: resample at 1/4/8/16 clocks, three equal samples accepted
// [R15] slow: sample at slow clock over four, two equal samples
// [R16] source 4 codes: rise, fall, both, high level
// [R17] deep modes halt sampling; resume on run, idle or sleep
// [R18] reserved code on sources 1-3 raises no request
// [R19] source 5 behaves as source 0
module eif_top
#(
  parameter NSRC = 6
)
(
  input wire hclk,
  input wire hresetn,
  input wire hsel,
  input wire [31:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [2:0] hsize,
  input wire [31:0] hwdata,
  input wire hready,
  output reg [31:0] hrdata,
  output reg hreadyout,
  output reg hresp,
  input wire low_freq_clock,
  input wire fixed_irq_pin_a_n,
  input wire prog_irq_pin_1,
  input wire prog_irq_pin_2,
  input wire prog_irq_pin_3,
  input wire prog_irq_pin_level_capable,
  input wire fixed_irq_pin_b_n,
  output reg [5:0] irq_req_q
);
  // ***************************************************************
  // register state
  // ***************************************************************
  reg clock_gate_enable_q;
  reg [1:0] mode_q;
  reg [1:0] es_q [1:4];
  reg [1:0] nc_q [1:4];
  reg [5:0] lvl_q;
  reg wr_pend_q;
  reg [7:0] wr_addr_q;
  reg lfc_q;
  reg [1:0] sdiv_q;
  reg [3:0] pre_q;
  wire [5:0] filt;
  wire [5:0] req;
  wire [5:0] lvl_hit;
  wire [5:0] pins = {fixed_irq_pin_b_n, prog_irq_pin_level_capable, prog_irq_pin_3,
    prog_irq_pin_2, prog_irq_pin_1, fixed_irq_pin_a_n};
  wire slow = (mode_q == `EIF_MODE_SLOW);
  // both upper mode codes halt the filters
  wire run = clock_gate_enable_q && ((mode_q & `EIF_MODE_DEEP) == 2'h0); // [R9] [R17]
  // ***************************************************************
  // sampling enables
  // ***************************************************************
  // slow clock arrives as a level; its rising edges make the slow tick
  wire lf_tick = low_freq_clock & ~lfc_q;
  wire slow_smp = lf_tick && (sdiv_q == `EIF_SLOW_DIV); // [R15]
  function fast_tick;
    input [1:0] nc;
    input [3:0] pre;
    begin
      case (nc) // [R14]
        `EIF_NC_1: fast_tick = 1'b1;
        `EIF_NC_4: fast_tick = (pre[1:0] == 2'h0);
        `EIF_NC_8: fast_tick = (pre[2:0] == 3'h0);
        default: fast_tick = (pre == 4'h0);
      endcase
    end
  endfunction
  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      lfc_q <= 1'b0;
      sdiv_q <= 2'h0;
      pre_q <= 4'h0;
    end
    else if (run)
    begin
      lfc_q <= low_freq_clock;
      if (lf_tick)
        sdiv_q <= sdiv_q + 2'h1;
      pre_q <= pre_q + 4'h1;
    end
  end
  // ***************************************************************
  // per-source filters
  // ***************************************************************
  genvar g;
  generate
    for (g = 0; g < NSRC; g = g + 1)
    begin : src
      localparam FIX = (g == 0) || (g == NSRC - 1); // [R1]
      // fixed sources point at a valid slot; their codes never come from it
      localparam CIX = FIX ? 1 : g;
      wire [1:0] es_g = FIX ? `EIF_ES_FALL : es_q[CIX];
      wire [1:0] nc_g = FIX ? `EIF_NC_1 : nc_q[CIX];
      // fixed sources: two equal clock samples in fast modes [R3]
      wire smp = slow ? slow_smp : fast_tick(nc_g, pre_q); // [R4] [R6]
      wire [1:0] need = slow ? `EIF_SLOW_AGREE :
        (FIX ? `EIF_FIX_FAST_AGREE : `EIF_FAST_AGREE);
      eif_filter u_flt
      (
        .hclk(hclk),
        .hresetn(hresetn),
        .run(run),
        .pin(pins[g]),
        .smp_en(smp),
        .need(need),
        .es(es_g),
        .fixed(FIX ? 1'b1 : 1'b0),
        .filt_q(filt[g]),
        .req_q(req[g])
      );
      // high-level mode only exists on the level-capable source
      assign lvl_hit[g] = (g == `EIF_LVL_SRC) && run && (es_g == `EIF_ES_HIGH) && filt[g]; // [R16]
    end
  endgenerate
  // ***************************************************************
  // request and monitor registers
  // ***************************************************************
  wire [5:0] any_req = req | lvl_hit;
  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      irq_req_q <= 6'h0;
      lvl_q <= 6'h0;
    end
    else
    begin
      irq_req_q <= any_req;
      // only requesting sources take a fresh level; the rest keep theirs
      lvl_q <= (lvl_q & ~any_req) | (filt & any_req); // [R7]
    end
  end
  // ***************************************************************
  // ahb-lite slave: zero wait, always okay
  // ***************************************************************
  wire take = hsel && hready && htrans[1];
  // a write lands in its data phase, one cycle after the address was taken
  function wr_hit;
    input [7:0] a;
    input [7:0] ofs;
    begin
      wr_hit = wr_pend_q && (a == ofs);
    end
  endfunction
  function [31:0] rd_mux;
    input [7:0] a;
    input [1:0] m;
    input ge;
    input [5:0] l;
    begin
      case (a)
        `EIF_OFS_GATE: rd_mux = {31'h0, ge};
        `EIF_OFS_MODE: rd_mux = {30'h0, m};
        `EIF_OFS_CFG1: rd_mux = {27'h0, l[1], nc_q[1], es_q[1]};
        `EIF_OFS_CFG2: rd_mux = {27'h0, l[2], nc_q[2], es_q[2]};
        `EIF_OFS_CFG3: rd_mux = {27'h0, l[3], nc_q[3], es_q[3]};
        `EIF_OFS_CFG4: rd_mux = {27'h0, l[4], nc_q[4], es_q[4]}; // [R8]
        `EIF_OFS_STAT: rd_mux = {26'h0, l};
        default: rd_mux = 32'h0;
      endcase
    end
  endfunction
  integer i;
  // ***************************************************************
  // handshake and address capture
  // ***************************************************************
  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end
    else
    begin
      // no wait states and no error response
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end
  end
  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      wr_pend_q <= 1'b0;
      wr_addr_q <= 8'h0;
    end
    else
    begin
      wr_pend_q <= take && hwrite;
      wr_addr_q <= haddr[7:0];
    end
  end
  // ***************************************************************
  // read data
  // ***************************************************************
  // read data stands until the next read is taken
  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      hrdata <= 32'h0;
    else if (take && !hwrite)
      hrdata <= rd_mux(haddr[7:0], mode_q, clock_gate_enable_q, lvl_q); // [R8]
  end
  // ***************************************************************
  // control registers
  // ***************************************************************
  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      clock_gate_enable_q <= 1'b0; // [R10]
    else if (wr_hit(wr_addr_q, `EIF_OFS_GATE))
      clock_gate_enable_q <= hwdata[0]; // [R9]
  end
  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      mode_q <= `EIF_MODE_FAST;
    else if (wr_hit(wr_addr_q, `EIF_OFS_MODE))
      mode_q <= hwdata[1:0]; // [R17]
  end
  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      for (i = 1; i <= 4; i = i + 1)
      begin
        es_q[i] <= `EIF_ES_RISE;
        nc_q[i] <= `EIF_NC_1;
      end
    end
    else if (wr_hit(wr_addr_q, `EIF_OFS_CFG1) || wr_hit(wr_addr_q, `EIF_OFS_CFG2) ||
      wr_hit(wr_addr_q, `EIF_OFS_CFG3) || wr_hit(wr_addr_q, `EIF_OFS_CFG4))
    begin
      // indices 1..4 follow word offsets 0x08..0x14
      es_q[wr_addr_q[4:2] - 3'h1] <= hwdata[`EIF_ES_LSB +: 2]; // [R1] [R5]
      nc_q[wr_addr_q[4:2] - 3'h1] <= hwdata[`EIF_NC_LSB +: 2]; // [R14]
    end
  end
endmodule // eif_top

// [test_ext_irq_edge_noise_filter.sv]
// testbench for the six pin interrupt conditioner
`timescale 1ns/1ns
module test_ext_irq_edge_noise_filter;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] hrdata;
  logic hreadyout;
  logic hresp;
  logic lfc;
  logic [5:0] pin;
  logic [5:0] irq_req_q;
  logic [31:0] rd;
  int cnt [6];
  int err_total = 0;
  int comparisons = 0;
  always #10 hclk = ~hclk;
  eif_pins eif_pins_i (.hclk(hclk), .low_freq_clock(lfc), .pin_q(pin));
  eif_top eif_top_i (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .low_freq_clock(lfc),
    .fixed_irq_pin_a_n(pin[0]), .prog_irq_pin_1(pin[1]), .prog_irq_pin_2(pin[2]),
    .prog_irq_pin_3(pin[3]), .prog_irq_pin_level_capable(pin[4]), .fixed_irq_pin_b_n(pin[5]),
    .irq_req_q(irq_req_q));
  always @(posedge hclk)
  begin
    for (int i = 0; i < 6; i++)
      if (irq_req_q[i] === 1'b1)
        cnt[i] <= cnt[i] + 1;
  end
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= {24'h0, a};
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    comparisons++;
    if (g !== e)
    begin
      err_total++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic hit(input logic [5:0] m, input int w);
    cnt = '{default: 0};
    eif_pins_i.pulse(m, w);
    repeat (120) @(posedge hclk);
  endtask
  task automatic t_gate;
    bus(1'b0, 8'h00, 32'h0);
    chk("gate", 32'h0, rd);
    hit(6'h3f, 20);
    for (int s = 0; s < 6; s++)
      chk("gated", 32'h0, cnt[s]);
    bus(1'b1, 8'h00, 32'h1);
    hit(6'h21, 6);
    chk("src0", 32'h1, cnt[0]);
    chk("src5", 32'h1, cnt[5]);
  endtask
  task automatic t_edges;
    int e [4] = '{1, 1, 2, 0};
    for (int c = 0; c < 4; c++)
    begin
      for (int s = 1; s < 4; s++)
        bus(1'b1, 8'(4 + 4 * s), 32'(c));
      hit(6'h0e, 12);
      for (int s = 1; s < 4; s++)
        chk("edges", 32'(e[c]), cnt[s]);
      bus(1'b0, 8'h08, 32'h0);
      chk("monitor", 32'(c != 1), {31'h0, rd[4]});
    end
  endtask
  task automatic t_interval;
    bus(1'b1, 8'h08, 32'hc);
    hit(6'h02, 20);
    chk("short", 32'h0, cnt[1]);
    hit(6'h02, 60);
    chk("long", 32'h1, cnt[1]);
  endtask
  task automatic t_level;
    bus(1'b1, 8'h14, 32'hff);
    bus(1'b0, 8'h14, 32'h0);
    chk("cfg4 top", 32'h0, rd & 32'he0);
    repeat (100) @(posedge hclk);
    chk("level", 32'h1, {31'h0, irq_req_q[4]});
    bus(1'b1, 8'h14, 32'h0);
    bus(1'b0, 8'h40, 32'h0);
    chk("unmapped", 32'h0, rd);
  endtask
  task automatic t_slow;
    bus(1'b1, 8'h04, 32'h1);
    repeat (100) @(posedge hclk);
    hit(6'h21, 16);
    chk("slow short", 32'h0, cnt[0] + cnt[5]);
    hit(6'h21, 120);
    chk("slow long", 32'h2, cnt[0] + cnt[5]);
    bus(1'b1, 8'h04, 32'h2);
    hit(6'h21, 120);
    chk("deep", 32'h0, cnt[0]);
    bus(1'b1, 8'h04, 32'h0);
    repeat (60) @(posedge hclk);
    hit(6'h01, 8);
    chk("resume", 32'h1, cnt[0]);
  endtask
  task automatic print_verdict;
    $display("comparisons %0d mismatches %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  initial
  begin
    repeat (20) @(posedge hclk);
    hresetn <= 1'b1;
    t_gate;
    t_edges;
    t_interval;
    t_level;
    t_slow;
    print_verdict;
  end
  // generous bound: the sequence needs well under ten thousand cycles
  initial
  begin
    #400000;
    err_total++;
    print_verdict;
  end
endmodule // test_ext_irq_edge_noise_filter
